// *** uart_transmit_control_status_bench.sv ***
module uart_transmit_control_status_bench;
   timeunit 1ns;
   timeprecision 1ns;

`define CHK(name, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("wrong value %s expected %0h seen %0h", name, exp, got); \
      end \
   end

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        port_tx_level;
   logic        serial_tx_pin;
   logic        serial_tx_owned;
   logic        irq;
   logic        listen;
   logic        rx_pol;
   logic [3:0]  rx_bits;
   logic [11:0] rx_last;
   int          rx_count;
   int          stop_errs;
   int          mismatches;
   int          total_checks;
   int          n;
   logic [31:0] rd;
   logic        err;

   uts_tx_ctrl #(.DEPTH(4), .DIV_RESET(16'h0001)) dut
   (
      .pclk            (pclk),
      .presetn         (presetn),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .port_tx_level   (port_tx_level),
      .serial_tx_pin   (serial_tx_pin),
      .serial_tx_owned (serial_tx_owned),
      .irq             (irq)
   );

   // Divisor 3 gives four clocks per bit, so mid-bit sampling is clean.
   uts_remote_rx far_end
   (
      .pclk      (pclk),
      .line      (serial_tx_pin),
      .listen    (listen),
      .idle_pol  (rx_pol),
      .bit_cyc   (16'h0004),
      .nbits     (rx_bits),
      .rx_last   (rx_last),
      .rx_count  (rx_count),
      .stop_errs (stop_errs)
   );

   initial
   begin
      pclk = 1'b0;
      forever
         #5 pclk = ~pclk;
   end

   task automatic test_done;
      if (mismatches == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] ctrl(input logic [1:0] sel,
                                        input logic pol, brk, en);
      ctrl = 32'h00000000;
      ctrl[uts_pkg::BIT_IRQ_SEL_HI] = sel[1];
      ctrl[uts_pkg::BIT_IRQ_SEL_LO] = sel[0];
      ctrl[uts_pkg::BIT_IDLE_POL] = pol;
      ctrl[uts_pkg::BIT_SYNC_BREAK] = brk;
      ctrl[uts_pkg::BIT_TX_ENABLE] = en;
   endfunction

   task automatic expect_frame(input logic [11:0] exp);
      int c;
      c = rx_count;
      for (int k = 0; k < 400 && rx_count == c; k++)
         @(posedge pclk);
      `CHK("frame count", c + 1, rx_count)
      `CHK("frame data", exp, rx_last)
   endtask

   // Polarity changes glitch the line, so the receiver is muted meanwhile.
   task automatic set_pol(input logic pol);
      listen <= 1'b0;
      apb(1'b1, uts_pkg::OFS_STATUS_CONTROL, ctrl(2'h3, pol, 1'b0, 1'b1));
      repeat (4) @(posedge pclk);
      rx_pol <= pol;
      listen <= 1'b1;
   endtask

   initial
   begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      test_done();
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      port_tx_level = 1'b1;
      listen = 1'b0;
      rx_pol = 1'b1;
      rx_bits = 4'h8;
      mismatches = 0;
      total_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("irq after reset", 1'b0, irq)
      apb(1'b0, uts_pkg::OFS_STATUS_CONTROL, 32'h00000000);
      `CHK("status reset", 32'h00000100, rd)
      `CHK("pin by port", 1'b1, serial_tx_pin)
      apb(1'b1, uts_pkg::OFS_BAUD_DIV, 32'h00000003);
      apb(1'b1, uts_pkg::OFS_TX_DATA, 32'h0000005A);
      port_tx_level <= 1'b0;
      apb(1'b1, uts_pkg::OFS_STATUS_CONTROL, ctrl(0, 1, 0, 1) | 32'h1000);
      apb(1'b0, uts_pkg::OFS_STATUS_CONTROL, 32'h00000000);
      `CHK("status enabled", 32'h00004500, rd)
      `CHK("pin owned", 1'b1, serial_tx_owned)
      `CHK("idle high", 1'b1, serial_tx_pin)
      `CHK("write while off", 0, rx_count)
      // The receiver stays muted until the transmitter owns an idle line.
      listen <= 1'b1;
      for (int i = 0; i < 6; i++)
         apb(1'b1, uts_pkg::OFS_TX_DATA, 32'h000000A0 + i);
      apb(1'b0, uts_pkg::OFS_STATUS_CONTROL, 32'h00000000);
      `CHK("status full", 32'h00004600, rd)
      for (int i = 0; i < 5; i++)
         expect_frame(12'h0A0 + i[11:0]);
      repeat (80) @(posedge pclk);
      `CHK("dropped on full", 5, rx_count)
      apb(1'b0, uts_pkg::OFS_STATUS_CONTROL, 32'h00000000);
      `CHK("status drained", 32'h00004500, rd)
      apb(1'b1, uts_pkg::OFS_TX_DATA, 32'h00000011);
      apb(1'b1, uts_pkg::OFS_TX_DATA, 32'h00000022);
      repeat (10) @(posedge pclk);
      port_tx_level <= 1'b1;
      apb(1'b1, uts_pkg::OFS_STATUS_CONTROL, ctrl(0, 1, 0, 0));
      repeat (3) @(posedge pclk);
      `CHK("pin released", 1'b0, serial_tx_owned)
      `CHK("port level", 1'b1, serial_tx_pin)
      apb(1'b0, uts_pkg::OFS_STATUS_CONTROL, 32'h00000000);
      `CHK("status aborted", 32'h00004100, rd)
      repeat (80) @(posedge pclk);
      n = rx_count;
      apb(1'b1, uts_pkg::OFS_STATUS_CONTROL, ctrl(0, 1, 0, 1));
      repeat (100) @(posedge pclk);
      `CHK("buffer reset", n, rx_count)
      set_pol(1'b0);
      `CHK("idle low", 1'b0, serial_tx_pin)
      apb(1'b1, uts_pkg::OFS_TX_DATA, 32'h0000003C);
      expect_frame(12'h03C);
      set_pol(1'b1);
      apb(1'b1, uts_pkg::OFS_IRQ_ENABLE, 32'h00000002);
      rx_bits <= 4'hC;
      apb(1'b1, uts_pkg::OFS_STATUS_CONTROL, ctrl(3, 1, 1, 1));
      expect_frame(12'h000);
      repeat (10) @(posedge pclk);
      apb(1'b0, uts_pkg::OFS_STATUS_CONTROL, 32'h00000000);
      `CHK("break cleared", 32'h0000E500, rd)
      `CHK("break irq", 1'b1, irq)
      apb(1'b1, uts_pkg::OFS_IRQ_CLEAR, 32'h00000003);
      @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      rx_bits <= 4'h8;
      for (int s = 0; s < 4; s++)
      begin
         apb(1'b1, uts_pkg::OFS_STATUS_CONTROL, ctrl(s[1:0], 1, 0, 1));
         apb(1'b1, uts_pkg::OFS_IRQ_CLEAR, 32'h00000003);
         apb(1'b1, uts_pkg::OFS_TX_DATA, 32'h00000060 + s);
         expect_frame(12'h060 + s[11:0]);
         repeat (10) @(posedge pclk);
         apb(1'b0, uts_pkg::OFS_IRQ_STATUS, 32'h00000000);
         `CHK("tx event", (s != 3), rd[0])
         `CHK("masked irq", 1'b0, irq)
      end
      apb(1'b0, 12'h020, 32'h00000000);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 32'h00000000, rd)
      `CHK("stop bits", 0, stop_errs)
      test_done();
   end
endmodule

// *** uts_pkg.sv ***
package uts_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [11:0] OFS_STATUS_CONTROL = 12'h000;
   localparam logic [11:0] OFS_TX_DATA        = 12'h004;
   localparam logic [11:0] OFS_BAUD_DIV       = 12'h008;
   localparam logic [11:0] OFS_IRQ_STATUS     = 12'h00C;
   localparam logic [11:0] OFS_IRQ_CLEAR      = 12'h010;
   localparam logic [11:0] OFS_IRQ_ENABLE     = 12'h014;

   // Field positions in uart_status_control.
   localparam int BIT_IRQ_SEL_HI  = 15;
   localparam int BIT_IDLE_POL    = 14;
   localparam int BIT_IRQ_SEL_LO  = 13;
   localparam int BIT_SYNC_BREAK  = 11;
   localparam int BIT_TX_ENABLE   = 10;
   localparam int BIT_BUF_FULL    = 9;
   localparam int BIT_SHIFT_EMPTY = 8;

   // Interrupt status, clear and enable layout.
   localparam int IRQ_BIT_TX    = 0;
   localparam int IRQ_BIT_BREAK = 1;
   localparam int IRQ_WIDTH     = 2;

   // Interrupt select encodings.
   localparam logic [1:0] SEL_ON_LOAD  = 2'h0;
   localparam logic [1:0] SEL_ON_DONE  = 2'h1;
   localparam logic [1:0] SEL_ON_EMPTY = 2'h2;

   // Frame shape and reset values.
   localparam int          DATA_BITS      = 8;
   localparam int          BREAK_BITS     = 12;
   localparam logic [15:0] BAUD_DIV_RESET = 16'h0010;
   localparam int          DEPTH_DEFAULT  = 4;

   typedef struct packed {
      logic       brk;
      logic [7:0] data;
   } uts_frame_t;

   typedef enum logic [1:0] {
      SH_IDLE  = 2'h0,
      SH_START = 2'h1,
      SH_BITS  = 2'h3,
      SH_STOP  = 2'h2
   } uts_shift_state_t;

endpackage

// *** uts_remote_rx.sv ***
module uts_remote_rx
(
   input  wire logic        pclk,
   input  wire logic        line,
   input  wire logic        listen,
   input  wire logic        idle_pol,
   input  wire logic [15:0] bit_cyc,
   input  wire logic [3:0]  nbits,
   output logic      [11:0] rx_last,
   output int               rx_count,
   output int               stop_errs
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [11:0] word;

   // The receiver only listens; it never drives the line.
   initial
   begin
      rx_last = 12'h000;
      rx_count = 0;
      stop_errs = 0;
      forever
      begin
         @(posedge pclk);
         if (listen && line === ~idle_pol)
         begin
            // Sampling at mid-bit tolerates the one-cycle register delay.
            repeat (bit_cyc / 2) @(posedge pclk);
            word = 12'h000;
            for (int i = 0; i < nbits; i++)
            begin
               repeat (bit_cyc) @(posedge pclk);
               word[i] = idle_pol ? line : ~line;
            end
            repeat (bit_cyc) @(posedge pclk);
            if (line !== idle_pol)
               stop_errs++;
            rx_last = word;
            rx_count++;
         end
      end
   end
endmodule

// *** uts_shifter.sv ***
module uts_shifter
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              bit_tick,
   input  wire logic              abort,
   input  wire logic              start,
   input  wire uts_pkg::uts_frame_t frame,
   output logic                   busy,
   output logic                   line_level,
   output logic                   done,
   output logic                   break_done
);

   uts_pkg::uts_shift_state_t state_reg;
   uts_pkg::uts_frame_t       frame_reg;
   logic [3:0]                cnt_reg;
   logic [3:0]                last_bit;

   assign last_bit = frame_reg.brk ? 4'(uts_pkg::BREAK_BITS - 1)
                                   : 4'(uts_pkg::DATA_BITS - 1);
   assign busy     = (state_reg != uts_pkg::SH_IDLE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= uts_pkg::SH_IDLE;
         frame_reg <= '0;
         cnt_reg   <= 4'h0;
      end
      else if (abort)
      begin
         state_reg <= uts_pkg::SH_IDLE;
         cnt_reg   <= 4'h0;
      end
      else
      begin
         unique case (state_reg)
            uts_pkg::SH_IDLE:
            begin
               if (start)
               begin
                  frame_reg <= frame;
                  cnt_reg   <= 4'h0;
                  state_reg <= uts_pkg::SH_START;
               end
            end
            uts_pkg::SH_START:
            begin
               if (bit_tick)
               begin
                  state_reg <= uts_pkg::SH_BITS;
               end
            end
            uts_pkg::SH_BITS:
            begin
               if (bit_tick)
               begin
                  if (cnt_reg == last_bit)
                  begin
                     state_reg <= uts_pkg::SH_STOP;
                  end
                  else
                  begin
                     cnt_reg <= cnt_reg + 4'h1;
                  end
               end
            end
            uts_pkg::SH_STOP:
            begin
               if (bit_tick)
               begin
                  state_reg <= uts_pkg::SH_IDLE;
               end
            end
         endcase
      end
   end

   // A break sends zeros in every bit slot instead of data bits.
   always_comb
   begin
      unique case (state_reg)
         uts_pkg::SH_IDLE:  line_level = 1'b1;
         uts_pkg::SH_START: line_level = 1'b0;
         uts_pkg::SH_BITS:  line_level = !frame_reg.brk &&
                                         frame_reg.data[cnt_reg[2:0]];
         uts_pkg::SH_STOP:  line_level = 1'b1;
      endcase
   end

   assign done = (state_reg == uts_pkg::SH_STOP) && bit_tick && !abort;
   assign break_done = done && frame_reg.brk;

endmodule

// *** uts_tx_ctrl.sv ***
module uts_tx_ctrl
#(
   parameter int          DEPTH     = uts_pkg::DEPTH_DEFAULT,
   parameter logic [15:0] DIV_RESET = uts_pkg::BAUD_DIV_RESET
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        port_tx_level,
   output logic             serial_tx_pin,
   output logic             serial_tx_owned,
   output logic             irq
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [1:0]          tx_irq_select_reg;
   logic                tx_idle_polarity_reg;
   logic                tx_sync_break_reg;
   logic                tx_enable_bit_reg;
   logic [15:0]         baud_div_reg;
   logic [15:0]         baud_cnt_reg;
   logic [uts_pkg::IRQ_WIDTH-1:0] irq_status_reg;
   logic [uts_pkg::IRQ_WIDTH-1:0] irq_enable_reg;
   logic [uts_pkg::IRQ_WIDTH-1:0] irq_event;
   logic [7:0]          buf_mem [DEPTH];
   logic [PW-1:0]       wr_ptr_reg;
   logic [PW-1:0]       rd_ptr_reg;
   logic [CW-1:0]       count_reg;
   logic [CW-1:0]       count_next;
   logic [31:0]         prdata_reg;
   logic                serial_tx_pin_reg;
   logic                access;
   logic                mapped;
   logic                ctl_wr;
   logic                data_wr;
   logic                abort;
   logic                bit_tick;
   logic                load;
   logic                push;
   logic                pop;
   logic                busy;
   logic                line_level;
   logic                shift_done;
   logic                break_done;
   logic                tx_buffer_full;
   logic                tx_shifter_empty;
   logic                tx_event;
   logic [15:0]         status_word;
   uts_pkg::uts_frame_t frame;

   assign access  = psel && penable;
   assign mapped  = (paddr == uts_pkg::OFS_STATUS_CONTROL) ||
                    (paddr == uts_pkg::OFS_TX_DATA) ||
                    (paddr == uts_pkg::OFS_BAUD_DIV) ||
                    (paddr == uts_pkg::OFS_IRQ_STATUS) ||
                    (paddr == uts_pkg::OFS_IRQ_CLEAR) ||
                    (paddr == uts_pkg::OFS_IRQ_ENABLE);
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata  = prdata_reg;
   assign ctl_wr  = access && pwrite &&
                    (paddr == uts_pkg::OFS_STATUS_CONTROL);
   assign data_wr = access && pwrite && (paddr == uts_pkg::OFS_TX_DATA);

   // Abort acts in the same edge that clears the enable bit.
   assign abort = ctl_wr && !pwdata[uts_pkg::BIT_TX_ENABLE];

   // Control fields; bit twelve has no storage at all.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_irq_select_reg    <= uts_pkg::SEL_ON_LOAD;
         tx_idle_polarity_reg <= 1'b0;
         tx_enable_bit_reg    <= 1'b0;
      end
      else if (ctl_wr)
      begin
         tx_irq_select_reg    <= {pwdata[uts_pkg::BIT_IRQ_SEL_HI],
                                  pwdata[uts_pkg::BIT_IRQ_SEL_LO]};
         tx_idle_polarity_reg <= pwdata[uts_pkg::BIT_IDLE_POL];
         tx_enable_bit_reg    <= pwdata[uts_pkg::BIT_TX_ENABLE];
      end
   end

   // A software write in the completion cycle wins over the hardware clear.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_sync_break_reg <= 1'b0;
      end
      else if (ctl_wr)
      begin
         tx_sync_break_reg <= pwdata[uts_pkg::BIT_SYNC_BREAK];
      end
      else if (break_done)
      begin
         tx_sync_break_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         baud_div_reg   <= DIV_RESET;
         irq_enable_reg <= '0;
      end
      else if (access && pwrite)
      begin
         if (paddr == uts_pkg::OFS_BAUD_DIV)
         begin
            baud_div_reg <= pwdata[15:0];
         end
         if (paddr == uts_pkg::OFS_IRQ_ENABLE)
         begin
            irq_enable_reg <= pwdata[uts_pkg::IRQ_WIDTH-1:0];
         end
      end
   end

   // Restarting the divider on load keeps the start bit a full bit long.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         baud_cnt_reg <= 16'h0000;
      end
      else if (load || bit_tick || !tx_enable_bit_reg)
      begin
         baud_cnt_reg <= 16'h0000;
      end
      else
      begin
         baud_cnt_reg <= baud_cnt_reg + 16'h0001;
      end
   end

   assign bit_tick = tx_enable_bit_reg && (baud_cnt_reg == baud_div_reg);

   // Writes to a full or disabled buffer are dropped silently.
   assign tx_buffer_full   = (count_reg == CW'(DEPTH));
   assign push  = data_wr && tx_enable_bit_reg && !tx_buffer_full;
   assign load  = tx_enable_bit_reg && !abort && !busy &&
                  (tx_sync_break_reg || (count_reg != '0));
   assign pop   = load && !tx_sync_break_reg;
   assign count_next = count_reg + CW'(push) - CW'(pop);
   assign frame = '{brk: tx_sync_break_reg, data: buf_mem[rd_ptr_reg]};

   always_ff @(posedge pclk)
   begin
      if (push)
      begin
         buf_mem[wr_ptr_reg] <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else if (abort)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0
                                                         : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0
                                                         : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_next;
      end
   end

   uts_shifter u_shifter
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .bit_tick   (bit_tick),
      .abort      (abort),
      .start      (load),
      .frame      (frame),
      .busy       (busy),
      .line_level (line_level),
      .done       (shift_done),
      .break_done (break_done)
   );

   assign tx_shifter_empty = !busy && (count_reg == '0);

   always_comb
   begin
      unique case (tx_irq_select_reg)
         uts_pkg::SEL_ON_LOAD:  tx_event = pop;
         uts_pkg::SEL_ON_DONE:  tx_event = shift_done && (count_next == '0);
         uts_pkg::SEL_ON_EMPTY: tx_event = pop && (count_next == '0);
         default:               tx_event = 1'b0;
      endcase
   end

   assign irq_event = {break_done, tx_event};

   // Per bit, a new event wins over a clear in the same cycle.
   for (genvar i = 0; i < uts_pkg::IRQ_WIDTH; i++)
   begin : g_irq
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            irq_status_reg[i] <= 1'b0;
         end
         else if (irq_event[i])
         begin
            irq_status_reg[i] <= 1'b1;
         end
         else if (access && pwrite &&
                  paddr == uts_pkg::OFS_IRQ_CLEAR && pwdata[i])
         begin
            irq_status_reg[i] <= 1'b0;
         end
      end
   end

   assign irq = |(irq_status_reg & irq_enable_reg);

   // The pin is registered so it never glitches on the mux select.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         serial_tx_pin_reg <= 1'b0;
      end
      else if (tx_enable_bit_reg)
      begin
         serial_tx_pin_reg <= tx_idle_polarity_reg ? line_level
                                                   : !line_level;
      end
      else
      begin
         serial_tx_pin_reg <= port_tx_level;
      end
   end

   assign serial_tx_pin   = serial_tx_pin_reg;
   assign serial_tx_owned = tx_enable_bit_reg;

   assign status_word = {tx_irq_select_reg[1], tx_idle_polarity_reg,
                         tx_irq_select_reg[0], 1'b0,
                         tx_sync_break_reg, tx_enable_bit_reg,
                         tx_buffer_full, tx_shifter_empty, 8'h00};

   // Read data is captured in the setup cycle and shown in the access.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= 32'h00000000;
      end
      else if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            uts_pkg::OFS_STATUS_CONTROL: prdata_reg <= {16'h0000, status_word};
            uts_pkg::OFS_BAUD_DIV:   prdata_reg <= {16'h0000, baud_div_reg};
            uts_pkg::OFS_IRQ_STATUS:
               prdata_reg <= {30'h00000000, irq_status_reg};
            uts_pkg::OFS_IRQ_ENABLE:
               prdata_reg <= {30'h00000000, irq_enable_reg};
            default:                 prdata_reg <= 32'h00000000;
         endcase
      end
   end

   chk_idle_level: assert property (@(posedge pclk) disable iff (!presetn)
      tx_enable_bit_reg && !busy && !ctl_wr |=>
      serial_tx_pin == tx_idle_polarity_reg)
      else $error("Idle line level does not follow polarity bit.");

   chk_break_clear: assert property (@(posedge pclk) disable iff (!presetn)
      break_done && !ctl_wr |=> !tx_sync_break_reg)
      else $error("Break bit not cleared after break frame.");

   chk_break_low: assert property (@(posedge pclk) disable iff (!presetn)
      load && tx_sync_break_reg && tx_idle_polarity_reg && !ctl_wr
      ##1 !ctl_wr |=> !serial_tx_pin)
      else $error("Break frame does not drive the line active.");

   chk_pin_owned: assert property (@(posedge pclk) disable iff (!presetn)
      ctl_wr && pwdata[uts_pkg::BIT_TX_ENABLE] |=> serial_tx_owned)
      else $error("Transmitter did not take the pin when enabled.");

   chk_disable_flush: assert property (@(posedge pclk) disable iff (!presetn)
      abort |=> count_reg == '0 && !busy && !serial_tx_owned)
      else $error("Disable did not abort and empty the buffer.");

   chk_full_refuse: assert property (@(posedge pclk) disable iff (!presetn)
      tx_buffer_full && data_wr && !load && !abort |=>
      $stable(count_reg) && tx_buffer_full)
      else $error("Write to a full buffer changed its fill.");

   chk_shifter_flag: assert property (@(posedge pclk) disable iff (!presetn)
      load |=> !tx_shifter_empty)
      else $error("Shifter empty flag high while shifting.");

   chk_bit12_zero: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pwrite && paddr == uts_pkg::OFS_STATUS_CONTROL |->
      prdata[12] == 1'b0)
      else $error("Unimplemented bit twelve read as one.");

   chk_irq_load: assert property (@(posedge pclk) disable iff (!presetn)
      pop && tx_irq_select_reg == uts_pkg::SEL_ON_LOAD |=>
      irq_status_reg[uts_pkg::IRQ_BIT_TX])
      else $error("Load interrupt not raised on shifter load.");

   cov_break_done: cover property (@(posedge pclk) disable iff (!presetn)
      break_done);
   cov_buffer_full: cover property (@(posedge pclk) disable iff (!presetn)
      tx_buffer_full && busy);
   cov_irq_out: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(irq));
   cov_abort_busy: cover property (@(posedge pclk) disable iff (!presetn)
      abort && busy);

endmodule
